// ### design/csu_chip_select.sv
`timescale 1ns/10ps
//Function
//- twelve programmable selects, fast two-cycle access
//- block size 2K to 1M, all eight sizes usable
//- assertion follows address or data strobe
//- one shared size acknowledge generator
//- optional timing against e-clock output
//- all access attributes must match to assert
//- select outputs are active low
//- boot registers hold bootstrap defaults at reset
//- internal module hit keeps select deasserted
//- boot select asserts after reset, all modes
//- single-chip: pins 1 to 9 take default function
//- expanded: selects wait for programmed size
//- pin sharing of selects, discretes, e-clock
//- port data register holds discrete values
//- pin fields choose 8 or 16-bit port
//- overlapping blocks are accepted unchanged
//- option register holds eight assertion fields
//- pin function bits 15:14 read zero
//- one two-bit field per pin
//- field decode 00 dout 01 default 1x select
//- data line strap picks select or default
//- discrete pins 3 to 9 drive port data bits
module csu_chip_select
  import csu_pkg::*;
#(
  parameter int E_HALF = CSU_E_HALF
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [5:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // core bus cycle
  input  wire logic        bus_as,
  input  wire logic        bus_ds,
  input  wire logic [23:0] bus_addr,
  input  wire logic        bus_read,
  input  wire logic [1:0]  bus_siz,
  input  wire logic [2:0]  bus_fc,
  input  wire logic        bus_internal_hit,
  // reset straps from pins
  input  wire logic        strap_single_chip,
  input  wire logic        strap_full_expanded,
  input  wire logic [7:0]  strap_data,
  // select pins
  output logic             boot_select_n,
  output logic [10:0]      pin_out,
  output logic [10:0]      pin_default,
  output logic             e_clock_out,
  // internal termination
  output logic [1:0]       size_acknowledge_n,
  output logic             avec_n
);

  logic [15:0] base_reg [CSU_NSEL];
  logic [15:0] opt_reg  [CSU_NSEL];
  logic [1:0]  fld_reg  [CSU_NSEL];
  logic [6:0]  discrete_out_data_reg;
  logic [9:0]  strap_s1_reg;
  logic [9:0]  strap_s2_reg;
  logic [1:0]  cfg_cnt_reg;
  logic        cfg_done_reg;
  logic [CSU_NSEL-1:0] hit;
  logic [CSU_NSEL-1:0] assert_now;
  logic [CSU_NSEL-1:0] sel_act_reg;
  logic [7:0]  e_cnt_reg;
  logic        e_clk_reg;
  csu_ack_t    ack_state_reg;
  logic [3:0]  ack_cnt_reg;
  logic        ack_wide_reg;
  logic        as_d_reg;

  function automatic logic [12:0] blk_mask(input logic [2:0] sz);
    logic [12:0] m;
    m = 13'h1FFF;
    case (sz)
      3'h0: m = 13'h1FFF;
      3'h1: m = 13'h1FFC;
      3'h2: m = 13'h1FF8;
      3'h3: m = 13'h1FE0;
      3'h4: m = 13'h1FC0;
      3'h5: m = 13'h1F80;
      3'h6: m = 13'h1F00;
      default: m = 13'h1E00;
    endcase
    return m;
  endfunction

  // strap line feeding the upper field bit of entries 1 to 11
  function automatic int strap_bit(input int i);
    int b;
    b = 0;
    if (i == 0) begin
      b = 0;
    end else if (i <= 3) begin
      b = 1;
    end else if (i <= 6) begin
      b = 2;
    end else begin
      b = i - 4;
    end
    return b;
  endfunction

  // straps come from pins, so two flops before use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      strap_s1_reg <= 10'h3FF;
      strap_s2_reg <= 10'h3FF;
    end else begin
      strap_s1_reg <= {strap_single_chip, strap_full_expanded, strap_data};
      strap_s2_reg <= strap_s1_reg;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_cnt_reg  <= 2'h0;
      cfg_done_reg <= 1'b0;
    end else if (!cfg_done_reg) begin
      cfg_cnt_reg  <= cfg_cnt_reg + 2'h1;
      cfg_done_reg <= (cfg_cnt_reg == 2'h2);
    end
  end

  // pin fields: strap load once after release, then software
  generate
    for (genvar i = 0; i < CSU_NSEL; i++) begin : g_fld
      // entries 0..6 live in function register 0, the rest in register 1
      localparam int         FPOS  = (i < 7) ? 2 * i : 2 * (i - 7);
      localparam logic [5:0] FADDR = (i < 7) ? CSU_PIN_FUNC0 : CSU_PIN_FUNC1;
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          fld_reg[i] <= CSU_FLD_RST;
        end else if (!cfg_done_reg && cfg_cnt_reg == 2'h2) begin
          if (strap_s2_reg[9] && i != 0 && i != 1 && i != 11) begin
            fld_reg[i] <= CSU_FN_DEFAULT;
          end else if (strap_s2_reg[8]) begin
            // boot keeps its select function, the strap only picks its port size
            fld_reg[i] <= (i == 0) ? {1'b1, strap_s2_reg[0]}
                                   : {strap_s2_reg[strap_bit(i)], 1'b1};
          end else begin
            fld_reg[i] <= CSU_FLD_RST;
          end
        end else if (reg_wr && reg_addr == FADDR) begin
          fld_reg[i] <= reg_wdata[FPOS+:2];
        end
      end

      // overlapping programming is stored as written
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          base_reg[i] <= (i == 0) ? CSU_BOOT_BASE_RST : CSU_BASE_RST;
          opt_reg[i]  <= (i == 0) ? CSU_BOOT_OPT_RST : CSU_OPT_RST;
        end else if (reg_wr && reg_addr == CSU_BASE0 + 6'(i)) begin
          base_reg[i] <= reg_wdata;
        end else if (reg_wr && reg_addr == CSU_OPT0 + 6'(i)) begin
          opt_reg[i] <= reg_wdata;
        end
      end

      // match logic, one copy per select
      logic [12:0] amask;
      logic        a_ok;
      logic        cpu_sp;
      logic        sp_ok;
      logic        rw_ok;
      logic        byte_ok;
      logic [1:0]  bsel;
      logic [1:0]  sp;
      logic [1:0]  rw;
      logic [2:0]  ipl;
      assign amask  = blk_mask(base_reg[i][CSU_B_BLKSZ+:3]);
      assign a_ok   = ((bus_addr[23:11] ^ base_reg[i][CSU_B_ADDR+:13]) & amask) == 13'h0000;
      assign cpu_sp = (bus_fc == CSU_FC_CPU);
      assign sp     = opt_reg[i][CSU_O_SPACE+:2];
      assign rw     = opt_reg[i][CSU_O_RW+:2];
      assign ipl    = opt_reg[i][CSU_O_IPL+:3];
      assign bsel   = opt_reg[i][CSU_O_BYTE+:2];
      always_comb begin
        sp_ok = 1'b0;
        case (sp)
          2'h0: sp_ok = cpu_sp && (ipl == 3'h0 || ipl == bus_addr[3:1]);
          2'h1: sp_ok = !cpu_sp && !bus_fc[2];
          2'h2: sp_ok = !cpu_sp && bus_fc[2];
          default: sp_ok = !cpu_sp;
        endcase
      end
      assign rw_ok = bus_read ? rw[0] : rw[1];
      // 8-bit port or non-select pin: any enabled byte lane matches
      always_comb begin
        byte_ok = 1'b0;
        if (bsel == 2'h0) begin
          byte_ok = 1'b0;
        end else if (fld_reg[i] != CSU_FN_SEL16) begin
          byte_ok = 1'b1;
        end else begin
          byte_ok = (bsel[0] && (bus_addr[0] || bus_siz != 2'h1))
                  || (bsel[1] && !bus_addr[0]);
        end
      end
      assign hit[i] = bus_as && !bus_internal_hit && sp_ok && rw_ok && byte_ok
                      && (cpu_sp || a_ok);
      assign assert_now[i] = hit[i] && fld_reg[i][1]
                      && (opt_reg[i][CSU_O_STRB] ? bus_ds : 1'b1)
                      && (opt_reg[i][CSU_O_MODE] ? e_clk_reg : 1'b1);
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      discrete_out_data_reg <= CSU_DOUT_RST;
    end else if (reg_wr && reg_addr == CSU_DOUT) begin
      discrete_out_data_reg <= reg_wdata[6:0];
    end
  end

  // e-clock divider
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      e_cnt_reg <= 8'h00;
      e_clk_reg <= 1'b0;
    end else if (e_cnt_reg == 8'(E_HALF - 1)) begin
      e_cnt_reg <= 8'h00;
      e_clk_reg <= !e_clk_reg;
    end else begin
      e_cnt_reg <= e_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_act_reg <= '0;
    end else begin
      sel_act_reg <= assert_now;
    end
  end

  // boot entry resets enabled, so it fires right after reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      boot_select_n <= 1'b1;
    end else begin
      boot_select_n <= !assert_now[0];
    end
  end

  // pin multiplexer: select j+1 sits on pin j
  generate
    for (genvar j = 0; j < 11; j++) begin : g_pin
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pin_out[j]     <= 1'b1;
          pin_default[j] <= 1'b0;
        end else begin
          pin_default[j] <= (fld_reg[j+1] == CSU_FN_DEFAULT) && j != 10;
          if (fld_reg[j+1][1]) begin
            pin_out[j] <= !assert_now[j+1];
          end else if (j == 10) begin
            pin_out[j] <= e_clk_reg;
          end else if (fld_reg[j+1] == CSU_FN_DISCRETE && j >= 3) begin
            pin_out[j] <= discrete_out_data_reg[(j >= 3) ? j - 3 : 0];
          end else begin
            pin_out[j] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      e_clock_out <= 1'b0;
    end else begin
      e_clock_out <= e_clk_reg;
    end
  end

  // shared acknowledge: lowest-index hit with internal ack wins;
  // equal wait counts are expected where selects overlap
  logic        ack_any;
  logic [3:0]  ack_pick;
  logic        ack_pick_wide;
  logic        avec_any;
  always_comb begin
    ack_any       = 1'b0;
    ack_pick      = 4'h0;
    ack_pick_wide = 1'b1;
    avec_any      = 1'b0;
    for (int k = CSU_NSEL - 1; k >= 0; k--) begin
      if (hit[k] && opt_reg[k][CSU_O_ACK+:4] != CSU_ACK_EXT) begin
        ack_any       = 1'b1;
        ack_pick      = opt_reg[k][CSU_O_ACK+:4];
        ack_pick_wide = (fld_reg[k] != CSU_FN_SEL8);
      end
      if (hit[k] && opt_reg[k][CSU_O_AVEC] && bus_fc == CSU_FC_CPU) begin
        avec_any = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      as_d_reg <= 1'b0;
    end else begin
      as_d_reg <= bus_as;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_state_reg <= CSU_ACK_IDLE;
      ack_cnt_reg   <= 4'h0;
      ack_wide_reg  <= 1'b1;
    end else begin
      case (ack_state_reg)
        CSU_ACK_IDLE: begin
          if (bus_as && !as_d_reg && ack_any) begin
            ack_wide_reg  <= ack_pick_wide;
            ack_cnt_reg   <= (ack_pick == CSU_ACK_FAST) ? 4'h0 : ack_pick;
            ack_state_reg <= (ack_pick == CSU_ACK_FAST || ack_pick == 4'h0)
                             ? CSU_ACK_DONE : CSU_ACK_WAIT;
          end
        end
        CSU_ACK_WAIT: begin
          if (!bus_as) begin
            ack_state_reg <= CSU_ACK_IDLE;
          end else if (ack_cnt_reg == 4'h1) begin
            ack_state_reg <= CSU_ACK_DONE;
          end
          ack_cnt_reg <= ack_cnt_reg - 4'h1;
        end
        CSU_ACK_DONE: begin
          if (!bus_as) begin
            ack_state_reg <= CSU_ACK_IDLE;
          end
        end
        default: ack_state_reg <= CSU_ACK_IDLE;
      endcase
    end
  end

  // acknowledge lines: 10 means 8-bit port, 01 means 16-bit port
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      size_acknowledge_n <= 2'h3;
      avec_n             <= 1'b1;
    end else begin
      if (ack_state_reg == CSU_ACK_DONE && bus_as) begin
        size_acknowledge_n <= ack_wide_reg ? 2'h1 : 2'h2;
      end else begin
        size_acknowledge_n <= 2'h3;
      end
      avec_n <= !avec_any;
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr == CSU_PIN_FUNC0) begin
        reg_rdata <= {2'h0, fld_reg[6], fld_reg[5], fld_reg[4], fld_reg[3],
                      fld_reg[2], fld_reg[1], fld_reg[0]};
      end else if (reg_addr == CSU_PIN_FUNC1) begin
        reg_rdata <= {6'h00, fld_reg[11], fld_reg[10], fld_reg[9], fld_reg[8],
                      fld_reg[7]};
      end else if (reg_addr == CSU_DOUT) begin
        reg_rdata <= {9'h000, discrete_out_data_reg};
      end else if (reg_addr == CSU_STATUS) begin
        reg_rdata <= {2'h0, e_clk_reg, ack_state_reg != CSU_ACK_IDLE, sel_act_reg};
      end else if (reg_addr >= CSU_BASE0 && reg_addr < CSU_BASE0 + 6'(CSU_NSEL)) begin
        reg_rdata <= base_reg[4'(reg_addr - CSU_BASE0)];
      end else if (reg_addr >= CSU_OPT0 && reg_addr < CSU_OPT0 + 6'(CSU_NSEL)) begin
        reg_rdata <= opt_reg[4'(reg_addr - CSU_OPT0)];
      end else begin
        reg_rdata <= 16'h0000;
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule

// ### design/csu_pkg.sv
package csu_pkg;
  // register map, index on the plain register port
  localparam logic [5:0] CSU_PIN_FUNC0 = 6'h00;
  localparam logic [5:0] CSU_PIN_FUNC1 = 6'h01;
  localparam logic [5:0] CSU_DOUT      = 6'h02;
  localparam logic [5:0] CSU_STATUS    = 6'h03;
  localparam logic [5:0] CSU_BASE0     = 6'h10;
  localparam logic [5:0] CSU_OPT0      = 6'h20;
  localparam int         CSU_NSEL      = 12;

  // reset values
  localparam logic [15:0] CSU_BOOT_BASE_RST = 16'h0007;
  localparam logic [15:0] CSU_BASE_RST      = 16'h0000;
  localparam logic [15:0] CSU_BOOT_OPT_RST  = 16'h7B70;
  localparam logic [15:0] CSU_OPT_RST       = 16'h0000;
  localparam logic [6:0]  CSU_DOUT_RST      = 7'h7F;
  localparam logic [1:0]  CSU_FLD_RST       = 2'h3;

  // pin field encodings
  localparam logic [1:0] CSU_FN_DISCRETE = 2'h0;
  localparam logic [1:0] CSU_FN_DEFAULT  = 2'h1;
  localparam logic [1:0] CSU_FN_SEL8     = 2'h2;
  localparam logic [1:0] CSU_FN_SEL16    = 2'h3;

  // option field positions
  localparam int CSU_O_MODE  = 15;
  localparam int CSU_O_BYTE  = 13;
  localparam int CSU_O_RW    = 11;
  localparam int CSU_O_STRB  = 10;
  localparam int CSU_O_ACK   = 6;
  localparam int CSU_O_SPACE = 4;
  localparam int CSU_O_IPL   = 1;
  localparam int CSU_O_AVEC  = 0;

  // base field positions
  localparam int CSU_B_ADDR  = 3;
  localparam int CSU_B_BLKSZ = 0;

  localparam logic [3:0] CSU_ACK_FAST = 4'hE;
  localparam logic [3:0] CSU_ACK_EXT  = 4'hF;
  localparam logic [2:0] CSU_FC_CPU   = 3'h7;

  // e-clock half period in system clocks
  localparam int CSU_E_HALF = 4;

  typedef enum logic [2:0] {
    CSU_ACK_IDLE = 3'b001,
    CSU_ACK_WAIT = 3'b010,
    CSU_ACK_DONE = 3'b100
  } csu_ack_t;
endpackage

// ### verification/csu_chip_select_bench.sv
`timescale 1ns/10ps
module csu_chip_select_bench
  import csu_pkg::*;
;
  typedef struct packed {
    logic        wr;
    logic [5:0]  addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } csu_row_t;

  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  reg_addr = 6'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        bus_as = 1'b0;
  logic        bus_ds = 1'b0;
  logic [23:0] bus_addr = 24'h00_0000;
  logic        bus_read = 1'b0;
  logic [1:0]  bus_siz = 2'h2;
  logic [2:0]  bus_fc = 3'h6;
  logic        bus_internal_hit = 1'b0;
  logic        strap_single_chip = 1'b0;
  logic        strap_full_expanded = 1'b0;
  logic [7:0]  strap_data = 8'hFF;
  logic [15:0] reg_rdata;
  logic        boot_select_n;
  logic [10:0] pin_out;
  logic [10:0] pin_default;
  logic        e_clock_out;
  logic [1:0]  size_acknowledge_n;
  logic        avec_n;
  logic [15:0] sel_count;
  logic [15:0] rd_val;
  int          miscompares = 0;
  int          n_tests = 0;
  csu_row_t    rows [14] = '{
    '{1'b0, CSU_PIN_FUNC0, 16'h0000, 16'h3FFF}, '{1'b0, CSU_PIN_FUNC1, 16'h0000, 16'h03FF},
    '{1'b0, CSU_DOUT, 16'h0000, 16'h007F}, '{1'b0, CSU_BASE0, 16'h0000, 16'h0007},
    '{1'b0, CSU_OPT0, 16'h0000, 16'h7B70}, '{1'b0, CSU_BASE0 + 6'h01, 16'h0000, 16'h0000},
    '{1'b0, CSU_OPT0 + 6'h0B, 16'h0000, 16'h0000}, '{1'b0, 6'h3F, 16'h0000, 16'h0000},
    '{1'b1, 6'h3F, 16'hABCD, 16'h0000}, '{1'b1, CSU_PIN_FUNC0, 16'hFFFF, 16'h3FFF},
    '{1'b1, CSU_PIN_FUNC1, 16'hFFFF, 16'h03FF}, '{1'b1, CSU_BASE0 + 6'h01, 16'h0100, 16'h0100},
    '{1'b1, CSU_BASE0 + 6'h02, 16'h0100, 16'h0100}, '{1'b1, CSU_DOUT, 16'h007E, 16'h007E}};

  always #4 mclk = ~mclk;

  csu_chip_select i_dut (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_as(bus_as),
    .bus_ds(bus_ds), .bus_addr(bus_addr), .bus_read(bus_read), .bus_siz(bus_siz),
    .bus_fc(bus_fc), .bus_internal_hit(bus_internal_hit),
    .strap_single_chip(strap_single_chip), .strap_full_expanded(strap_full_expanded),
    .strap_data(strap_data), .boot_select_n(boot_select_n), .pin_out(pin_out),
    .pin_default(pin_default), .e_clock_out(e_clock_out),
    .size_acknowledge_n(size_acknowledge_n), .avec_n(avec_n)
  );

  csu_ext_mem i_mem (
    .mclk(mclk), .arst_n(arst_n), .sel_n(boot_select_n), .sel_count(sel_count)
  );

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: register %h, want %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: pin %b, want %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic cyc(input logic [23:0] a, input logic r, input logic hit);
    @(posedge mclk);
    bus_addr         <= a;
    bus_read         <= r;
    bus_internal_hit <= hit;
    bus_as           <= 1'b1;
    @(posedge mclk);
    #1;
  endtask

  task automatic stop;
    @(posedge mclk);
    bus_as           <= 1'b0;
    bus_internal_hit <= 1'b0;
    bus_ds           <= 1'b0;
    bus_fc           <= 3'h6;
    bus_siz          <= 2'h2;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset(input logic sc, input logic fe, input logic [7:0] db);
    @(posedge mclk);
    strap_single_chip   <= sc;
    strap_full_expanded <= fe;
    strap_data          <= db;
    arst_n              <= 1'b0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    // fields load from the straps late, so registers are left alone until then
    repeat (4) @(posedge mclk);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(1'b0, 1'b0, 8'hFF);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wdata);
      end
      rd(rows[i].addr, rd_val);
      chk_reg(rd_val, rows[i].exp);
    end
    cyc(24'h00_0100, 1'b1, 1'b0);
    chk_pin({1'b0, boot_select_n}, 2'h0);
    for (int k = 0; k < 40 && size_acknowledge_n === 2'h3; k++) begin
      @(posedge mclk);
      #1;
    end
    chk_pin(size_acknowledge_n, 2'h1);
    stop;
    chk_pin({1'b0, boot_select_n}, 2'h1);
    cyc(24'h00_0100, 1'b1, 1'b1);
    chk_pin({1'b0, boot_select_n}, 2'h1);
    stop;
    cyc(24'h01_0000, 1'b1, 1'b0);
    chk_pin({1'b0, pin_out[0]}, 2'h1);
    stop;
    wr(CSU_OPT0 + 6'h01, 16'h7BB0);
    wr(CSU_OPT0 + 6'h02, 16'h6BB0);
    cyc(24'h01_0000, 1'b1, 1'b0);
    chk_pin({1'b0, pin_out[0]}, 2'h0);
    chk_pin({1'b0, pin_out[1]}, 2'h0);
    stop;
    cyc(24'h01_0000, 1'b0, 1'b0);
    chk_pin({pin_out[0], pin_out[1]}, 2'h1);
    stop;
    cyc(24'h01_0800, 1'b1, 1'b0);
    chk_pin({1'b0, pin_out[0]}, 2'h1);
    stop;
    wr(CSU_PIN_FUNC0, 16'h34FF);
    @(posedge mclk);
    #1;
    chk_pin({pin_out[3], pin_default[4]}, 2'h1);
    wr(CSU_DOUT, 16'h007F);
    @(posedge mclk);
    #1;
    chk_pin({1'b0, pin_out[3]}, 2'h1);
    chk_reg(sel_count, 16'h0005);
    // data strobe timing: select waits for the strobe
    wr(CSU_OPT0 + 6'h01, 16'h7FB0);
    cyc(24'h01_0000, 1'b1, 1'b0);
    chk_pin({1'b0, pin_out[0]}, 2'h1);
    @(posedge mclk);
    bus_ds <= 1'b1;
    @(posedge mclk);
    #1;
    chk_pin({1'b0, pin_out[0]}, 2'h0);
    stop;
    // e-clock timing: select is low only in the high phase
    wr(CSU_OPT0 + 6'h01, 16'hFFB0);
    @(posedge mclk);
    bus_ds <= 1'b1;
    cyc(24'h01_0000, 1'b1, 1'b0);
    for (int k = 0; k < 8; k++) begin
      @(posedge mclk);
      #1;
      chk_pin({1'b0, pin_out[0] ^ e_clock_out}, 2'h1);
    end
    stop;
    // lower byte of a 16-bit port: even byte access misses, word hits
    wr(CSU_OPT0 + 6'h01, 16'h3BB0);
    @(posedge mclk);
    bus_siz <= 2'h1;
    cyc(24'h01_0000, 1'b1, 1'b0);
    chk_pin({1'b0, pin_out[0]}, 2'h1);
    stop;
    cyc(24'h01_0000, 1'b1, 1'b0);
    chk_pin({1'b0, pin_out[0]}, 2'h0);
    stop;
    // interrupt acknowledge at level 3 with autovector
    wr(CSU_OPT0 + 6'h02, 16'h7B87);
    @(posedge mclk);
    bus_fc <= 3'h7;
    cyc(24'h00_0006, 1'b1, 1'b0);
    chk_pin({pin_out[1], avec_n}, 2'h0);
    stop;
    @(posedge mclk);
    bus_fc <= 3'h7;
    cyc(24'h00_0004, 1'b1, 1'b0);
    chk_pin({pin_out[1], avec_n}, 2'h3);
    stop;
    do_reset(1'b1, 1'b0, 8'hFF);
    rd(CSU_PIN_FUNC0, rd_val);
    chk_reg(rd_val, 16'h155F);
    rd(CSU_PIN_FUNC1, rd_val);
    chk_reg(rd_val, 16'h0355);
    do_reset(1'b0, 1'b1, 8'hF4);
    rd(CSU_PIN_FUNC0, rd_val);
    chk_reg(rd_val, 16'h3F56);
    rd(CSU_PIN_FUNC1, rd_val);
    chk_reg(rd_val, 16'h03FD);
    give_verdict;
  end

  // whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    give_verdict;
  end
endmodule

// ### verification/csu_chip_select_checker.sv
`timescale 1ns/10ps
module csu_chip_select_checker
  import csu_pkg::*;
#(
  parameter int E_HALF = CSU_E_HALF
) (
  // clock, reset, register port
  input wire logic        mclk,
  input wire logic        arst_n,
  input wire logic [5:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // bus cycle
  input wire logic        bus_as,
  input wire logic        bus_internal_hit,
  // pins
  input wire logic        boot_select_n,
  input wire logic [10:0] pin_out,
  input wire logic [10:0] pin_default,
  input wire logic        e_clock_out,
  input wire logic [1:0]  size_acknowledge_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  logic       e_q_reg;
  logic       seen_reg;
  logic [7:0] e_cnt_reg;

  // phase after reset is free, so the period is only judged after a first toggle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      e_q_reg   <= 1'b0;
      seen_reg  <= 1'b0;
      e_cnt_reg <= 8'h00;
    end else begin
      e_q_reg   <= e_clock_out;
      seen_reg  <= seen_reg | (e_clock_out != e_q_reg);
      e_cnt_reg <= (e_clock_out != e_q_reg) ? 8'h00 : e_cnt_reg + 8'h01;
    end
  end

  AST_PAR_HI: assert property ($past(reg_rd) && $past(reg_addr) == CSU_PIN_FUNC0
    |-> reg_rdata[15:14] == 2'h0) else $error("pin function top bits not zero");
  AST_INT_HIT: assert property ($past(bus_internal_hit)
    |-> boot_select_n && pin_out[2:0] == 3'h7) else $error("select on internal hit");
  AST_BUS_IDLE: assert property (!$past(bus_as)
    |-> boot_select_n && pin_out[2:0] == 3'h7) else $error("select without bus cycle");
  AST_BOOT_FALL: assert property ($fell(boot_select_n)
    |-> $past(bus_as) && !$past(bus_internal_hit)) else $error("boot select without cause");
  AST_ACK_CODE: assert property (size_acknowledge_n != 2'h0)
    else $error("reserved size acknowledge code");
  AST_ACK_DROP: assert property (!$past(bus_as) |-> size_acknowledge_n == 2'h3)
    else $error("size acknowledge outside bus cycle");
  AST_E_CLOCK_OUT_PIN: assert property (pin_default[10] == 1'b0)
    else $error("e-clock pin shows default function");
  AST_E_CLOCK_OUT_MAX: assert property (seen_reg |-> e_cnt_reg < E_HALF)
    else $error("e-clock half period too long");
  AST_E_CLOCK_OUT_PER: assert property (seen_reg && e_clock_out != e_q_reg
    |-> e_cnt_reg == E_HALF - 1) else $error("e-clock half period wrong");

  CVR_BOOT: cover property (!boot_select_n);
  CVR_ACK: cover property (size_acknowledge_n == 2'h1);
  CVR_DEF: cover property (pin_default[4]);
endmodule

bind csu_chip_select csu_chip_select_checker #(.E_HALF(E_HALF)) u_chk (
  .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .bus_as(bus_as), .bus_internal_hit(bus_internal_hit),
  .boot_select_n(boot_select_n), .pin_out(pin_out), .pin_default(pin_default),
  .e_clock_out(e_clock_out), .size_acknowledge_n(size_acknowledge_n)
);

// ### verification/csu_ext_mem.sv
`timescale 1ns/10ps
module csu_ext_mem (
  // bus side
  input  wire logic        mclk,
  input  wire logic        arst_n,
  input  wire logic        sel_n,
  // observed selections
  output logic      [15:0] sel_count
);
  logic sel_q_reg;

  // the memory reacts to the falling edge only, each new selection counted once
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q_reg <= 1'b1;
      sel_count <= 16'h0000;
    end else begin
      sel_q_reg <= sel_n;
      if (sel_q_reg && !sel_n) begin
        sel_count <= sel_count + 16'h0001;
      end
    end
  end
endmodule
